// [ddrb_core.sv]
`timescale 1ns/1ns
module ddrb_core
  import ddrb_pkg::*;
#(
  parameter int DQ_W = 8,
  parameter int ROW_W = 2,
  parameter int COL_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic diff_clk_pos,
  input wire logic diff_clk_neg,
  input wire ddrb_cmd_t cmd_in,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_n,
  input wire logic dqs_i,
  output logic dqs_o,
  output logic dqs_oe_n,
  input wire logic [DQ_W/8-1:0] write_mask,
  output logic dll_reset_pulse,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int MW = DQ_W / 8;
  localparam int AW = 2 + ROW_W + COL_W;
  initial begin
    if (DQ_W % 8 != 0 || COL_W < 3 || COL_W > 12 || ROW_W < 1 || ROW_W > 13) begin
      $error("ddrb_core: unsupported parameters");
    end
  end

  // Burst length from length code; reserved codes fall back to 2
  function automatic logic [3:0] bl_of(input logic [2:0] c);
    case (c)
      DDRB_BL4: bl_of = 4'h4;
      DDRB_BL8: bl_of = 4'h8;
      default: bl_of = 4'h2;
    endcase
  endfunction : bl_of

  // Latency in half-periods from latency code
  function automatic logic [3:0] lat_of(input logic [2:0] c);
    case (c)
      DDRB_CL2: lat_of = DDRB_CL2_EDGES;
      DDRB_CL25: lat_of = DDRB_CL25_EDGES;
      default: lat_of = DDRB_CL3_EDGES;
    endcase
  endfunction : lat_of

  // Column of access k, wrapped in the aligned block
  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] s, input logic [2:0] k,
      input logic [3:0] bl, input logic ilv);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] lo;
    m = COL_W'(bl - 4'h1);
    lo = ilv ? (s ^ COL_W'(k)) : (s + COL_W'(k));
    col_at = (s & ~m) | (lo & m);
  endfunction : col_at

  // Pin synchronisers; stage one feeds stage two only
  logic lk_s1, lk_s2, lk_s3, ckn_s1, ckn_s2, dqs_s1, dqs_s2, dqs_s3;
  ddrb_cmd_t cmd_s1, cmd_s2;
  logic [DQ_W-1:0] dq_s1, dq_s2;
  logic [MW-1:0] msk_s1, msk_s2;
  always_ff @(posedge clk) begin
    lk_s1 <= diff_clk_pos;
    lk_s2 <= lk_s1;
    lk_s3 <= lk_s2;
    ckn_s1 <= diff_clk_neg;
    ckn_s2 <= ckn_s1;
    dqs_s1 <= dqs_i;
    dqs_s2 <= dqs_s1;
    dqs_s3 <= dqs_s2;
    cmd_s1 <= cmd_in;
    cmd_s2 <= cmd_s1;
    dq_s1 <= dq_i;
    dq_s2 <= dq_s1;
    msk_s1 <= write_mask;
    msk_s2 <= msk_s1;
  end

  // Rising edge is true high across its complement low
  logic lk_rise, lk_edge, dqs_edge;
  assign lk_rise = lk_s2 & ~lk_s3 & ~ckn_s2;
  assign lk_edge = lk_s2 ^ lk_s3;
  assign dqs_edge = dqs_s2 ^ dqs_s3;

  // Storage array, one n-bit word per column per stored row
  logic [DQ_W-1:0] mem [0:(1<<AW)-1];

  ddrb_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] beat_reg, beat_next;
  logic [1:0] bank_reg, bank_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic ap_reg, ap_next;
  logic [12:0] mode_reg, mode_next;
  logic [3:0] open_reg, open_next;
  logic [ROW_W-1:0] row_reg [0:3];
  logic [ROW_W-1:0] row_next [0:3];
  logic dll_reg, dll_next;
  logic [DQ_W-1:0] dqo_reg, dqo_next;
  logic dqs_reg, dqs_next, drv_reg, drv_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic mem_we;
  logic [AW-1:0] mem_a;
  logic [DQ_W-1:0] mem_d;

  logic [3:0] bl;
  logic [1:0] cbank;
  logic cmd_go;
  logic [COL_W-1:0] cur_col;
  assign bl = bl_of(mode_reg[DDRB_BL_LSB +: 3]);
  assign cbank = {cmd_s2.bank_sel_hi, cmd_s2.bank_sel_lo};
  assign cmd_go = lk_rise & ~cmd_s2.chip_sel_n & ctrl_reg[0];
  assign cur_col = col_at(col_reg, beat_reg, bl, mode_reg[DDRB_ORDER_BIT]);

  // Command decode and burst sequencing
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    beat_next = beat_reg;
    bank_next = bank_reg;
    col_next = col_reg;
    ap_next = ap_reg;
    mode_next = mode_reg;
    open_next = open_reg;
    row_next = row_reg;
    dll_next = 1'b0;
    dqo_next = dqo_reg;
    dqs_next = dqs_reg;
    drv_next = drv_reg;
    mem_we = 1'b0;
    mem_a = {bank_reg, row_reg[bank_reg], cur_col};
    mem_d = mem[mem_a];
    // Other banks may open and close during a burst
    if (cmd_go && cmd_s2.op == DDRB_CMD_ACT) begin
      open_next[cbank] = 1'b1;
      row_next[cbank] = cmd_s2.row_col_addr_bits[ROW_W-1:0];
    end
    if (cmd_go && cmd_s2.op == DDRB_CMD_PRE) begin
      if (cmd_s2.row_col_addr_bits[DDRB_AP_BIT]) begin
        open_next = 4'h0;
      end else begin
        open_next[cbank] = 1'b0;
      end
    end
    case (st_reg)
      DDRB_IDLE: begin
        // Mode load touches only the mode bits, never the array
        if (cmd_go && cmd_s2.op == DDRB_CMD_MRS && cbank == 2'h0) begin
          mode_next = cmd_s2.row_col_addr_bits;
          mode_next[DDRB_DLL_BIT] = 1'b0;
          dll_next = cmd_s2.row_col_addr_bits[12:7] == 6'h02;
        end
        // Accesses to a closed bank are dropped
        if (cmd_go && (cmd_s2.op == DDRB_CMD_RD || cmd_s2.op == DDRB_CMD_WR)
            && open_reg[cbank]) begin
          bank_next = cbank;
          col_next = cmd_s2.row_col_addr_bits[COL_W-1:0];
          ap_next = cmd_s2.row_col_addr_bits[DDRB_AP_BIT];
          beat_next = 3'h0;
          cnt_next = lat_of(mode_reg[DDRB_LAT_LSB +: 3]);
          st_next = cmd_s2.op == DDRB_CMD_RD ? DDRB_RD_WAIT : DDRB_WR_BURST;
        end
      end
      DDRB_RD_WAIT: begin
        if (lk_edge) begin
          cnt_next = cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            // First beat lands on edge n+m, strobe rising with it
            drv_next = 1'b1;
            dqs_next = 1'b1;
            dqo_next = mem_d;
            beat_next = 3'h1;
            st_next = DDRB_RD_BURST;
          end
        end
      end
      DDRB_RD_BURST: begin
        if (lk_edge) begin
          if ({1'b0, beat_reg} == bl || beat_reg == 3'h0) begin
            drv_next = 1'b0;
            dqs_next = 1'b0;
            if (ap_reg) begin
              open_next[bank_reg] = 1'b0;
            end
            st_next = DDRB_IDLE;
          end else begin
            dqo_next = mem_d;
            dqs_next = ~dqs_reg;
            beat_next = beat_reg + 3'h1;
          end
        end
      end
      DDRB_WR_BURST: begin
        if (dqs_edge) begin
          // Each masked lane keeps its old byte
          for (int i = 0; i < MW; i++) begin
            if (!msk_s2[i]) begin
              mem_d[i*8 +: 8] = dq_s2[i*8 +: 8];
            end
          end
          mem_we = ~&msk_s2;
          beat_next = beat_reg + 3'h1;
          if ({1'b0, beat_reg} == bl - 4'h1) begin
            if (ap_reg) begin
              open_next[bank_reg] = 1'b0;
            end
            st_next = DDRB_IDLE;
          end
        end
      end
      default: st_next = DDRB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= DDRB_IDLE;
      cnt_reg <= 4'h0;
      beat_reg <= 3'h0;
      bank_reg <= 2'h0;
      col_reg <= '0;
      ap_reg <= 1'b0;
      mode_reg <= DDRB_MODE_RST;
      open_reg <= 4'h0;
      row_reg <= '{default: '0};
      dll_reg <= 1'b0;
      dqo_reg <= '0;
      dqs_reg <= 1'b0;
      drv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      beat_reg <= beat_next;
      bank_reg <= bank_next;
      col_reg <= col_next;
      ap_reg <= ap_next;
      mode_reg <= mode_next;
      open_reg <= open_next;
      row_reg <= row_next;
      dll_reg <= dll_next;
      dqo_reg <= dqo_next;
      dqs_reg <= dqs_next;
      drv_reg <= drv_next;
    end
  end

  // Array write port; no reset so contents outlive mode loads
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_a] <= mem_d;
    end
  end

  assign dq_o = dqo_reg;
  assign dqs_o = dqs_reg;
  assign dq_oe_n = ~drv_reg;
  assign dqs_oe_n = ~drv_reg;
  assign dll_reset_pulse = dll_reg;

  // AXI4-Lite slave: address and data taken together, answer next cycle
  logic bv_reg, bv_next, rv_reg, rv_next;
  logic [1:0] br_reg, br_next, rr_reg, rr_next;
  logic [31:0] rd_reg, rd_next;
  logic wr_go, rd_go;
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bv_reg;
  assign rd_go = s_axi_arvalid & ~rv_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  always_comb begin
    ctrl_next = ctrl_reg;
    bv_next = bv_reg & ~s_axi_bready;
    br_next = br_reg;
    rv_next = rv_reg & ~s_axi_rready;
    rr_next = rr_reg;
    rd_next = rd_reg;
    if (wr_go) begin
      bv_next = 1'b1;
      br_next = 2'h2;
      if (s_axi_awaddr == DDRB_CTRL_OFS) begin
        br_next = 2'h0;
        if (s_axi_wstrb[0]) begin
          ctrl_next = {31'h0, s_axi_wdata[0]};
        end
      end
    end
    if (rd_go) begin
      rv_next = 1'b1;
      rr_next = 2'h0;
      case (s_axi_araddr)
        DDRB_MODE_OFS: rd_next = {19'h0, mode_reg};
        DDRB_STAT_OFS: rd_next = {24'h0, st_reg, open_reg};
        DDRB_CTRL_OFS: rd_next = ctrl_reg;
        default: begin
          rd_next = 32'h0;
          rr_next = 2'h2;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= DDRB_CTRL_RST;
      bv_reg <= 1'b0;
      br_reg <= 2'h0;
      rv_reg <= 1'b0;
      rr_reg <= 2'h0;
      rd_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rr_reg <= rr_next;
      rd_reg <= rd_next;
    end
  end
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rresp = rr_reg;
  assign s_axi_rdata = rd_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_MODE_LOAD: assert property (st_reg == DDRB_IDLE && cmd_go && cmd_s2.op == DDRB_CMD_MRS
      && cbank == 2'h0 |=> mode_reg == ($past(cmd_s2.row_col_addr_bits) & 13'h1EFF))
    else $error("mode not loaded");
  AST_DLL_SELF_CLEAR: assert property (dll_reg |=> !dll_reg && !mode_reg[DDRB_DLL_BIT])
    else $error("dll reset bit stuck");
  AST_ACT_OPENS: assert property (cmd_go && cmd_s2.op == DDRB_CMD_ACT
      && !(st_reg == DDRB_RD_BURST) |=> open_reg[$past(cbank)])
    else $error("bank not opened");
  AST_RD_LATENCY: assert property (st_reg == DDRB_RD_WAIT && lk_edge && cnt_reg == 4'h1
      |=> drv_reg && dqs_reg && !dq_oe_n)
    else $error("read data late");
  AST_STROBE_IDLE: assert property (st_reg inside {DDRB_IDLE, DDRB_WR_BURST}
      |-> dqs_oe_n && !dqs_reg)
    else $error("strobe driven outside read");
  AST_STROBE_TOGGLE: assert property (st_reg == DDRB_RD_BURST && drv_reg && lk_edge
      && beat_reg != 3'h0 && {1'b0, beat_reg} != bl |=> dqs_reg != $past(dqs_reg))
    else $error("strobe did not toggle");
  AST_WRAP_BLOCK: assert property (st_reg != DDRB_IDLE
      |-> (cur_col & ~COL_W'(bl - 4'h1)) == (col_reg & ~COL_W'(bl - 4'h1)))
    else $error("burst left its block");
  AST_AUTO_PRE: assert property (st_reg == DDRB_WR_BURST && dqs_edge && ap_reg
      && {1'b0, beat_reg} == bl - 4'h1 |=> !open_reg[$past(bank_reg)])
    else $error("auto precharge missed");
  AST_MASK_BLOCKS: assert property (st_reg == DDRB_WR_BURST && &msk_s2 |-> !mem_we)
    else $error("masked write stored");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  COV_READ: cover property (st_reg == DDRB_RD_BURST ##1 st_reg == DDRB_IDLE);
  COV_WRITE: cover property (st_reg == DDRB_WR_BURST ##1 st_reg == DDRB_IDLE);
  COV_DLL: cover property (dll_reg);
endmodule : ddrb_core

// [ddrb_ctl_model.sv]
`timescale 1ns/1ns
// Memory controller stand-in on the link side
module ddrb_ctl_model
  import ddrb_pkg::*;
(
  output logic diff_clk_pos,
  output logic diff_clk_neg,
  output ddrb_cmd_t cmd,
  output logic [7:0] dq,
  output logic dqs,
  output logic [0:0] write_mask
);
  realtime t_cmd;
  // Free-running link clock, phase unrelated to clk
  initial begin
    diff_clk_pos = 1'b0;
    #130;
    forever #400 diff_clk_pos = ~diff_clk_pos;
  end
  assign diff_clk_neg = ~diff_clk_pos;
  // Idle bus: deselected, strobe parked low
  initial begin
    cmd = '{1'b1, 3'h7, 1'b0, 1'b0, 13'h0000};
    dq = 8'h00;
    dqs = 1'b0;
    write_mask = 1'b0;
  end
  // Set up at the fall, held a full link cycle across the rise
  task automatic send(input logic [2:0] op, input logic [1:0] bk, input logic [12:0] a);
    @(negedge diff_clk_pos);
    cmd <= '{1'b0, op, bk[1], bk[0], a};
    @(posedge diff_clk_pos);
    t_cmd = $realtime;
    @(negedge diff_clk_pos);
    cmd <= '{1'b1, 3'h7, ~bk[1], ~bk[0], ~a};
  endtask : send
  // Strobe edge centred in each beat; no preamble edge
  task automatic burst(input logic [7:0] d [8], input logic [0:0] m [8], input int bl);
    for (int k = 0; k < bl; k++) begin
      dq <= d[k];
      write_mask <= m[k];
      #200 dqs <= ~dqs;
      #200;
    end
    dq <= ~d[bl-1];
    write_mask <= ~m[bl-1];
  endtask : burst
  // Quiet time after a loop reset before reads
  task automatic settle();
    repeat (200) @(posedge diff_clk_pos);
  endtask : settle
endmodule : ddrb_ctl_model

// [ddrb_pkg.sv]
// Operation
// - Commands and address are taken only on the rising edge of the true link clock.
// - Write data is taken on both strobe edges; read data leaves on both edges.
// - Device drives the strobe edge-aligned on reads; strobe idles outside transfers.
// - One 2n-bit core access per link clock, two n-bit pin beats; the core here accesses one n-bit array word per beat.
// - Read or write takes bank select and starting column from the address.
// - Burst length 2, 4 or 8, both orders, set by mode bits 2..0.
// - Mode bit 3 is order, bits 6..4 latency, bits 12..7 operating mode.
// - Mode set with bank selects zero stores mode; DLL reset bit self-clears.
// - Loading the mode leaves stored array contents unchanged.
// - Burst wraps inside an aligned block of burst-length columns.
// - Order bit picks sequential or interleaved column order.
// - Sequential uses start plus k, interleaved start xor k, within the block.
// - First read beat appears latency clocks after the read command.
// - Mode bits 12..7 zero is normal; only bit 8 set also resets the DLL.
// - Auto precharge closes the row by itself when the burst ends.
// - Four banks hold rows open independently.
// - Mask low lets a byte be written, high blocks it; reads unaffected.
package ddrb_pkg;
  // Register byte offsets
  localparam logic [3:0] DDRB_MODE_OFS = 4'h0;
  localparam logic [3:0] DDRB_STAT_OFS = 4'h4;
  localparam logic [3:0] DDRB_CTRL_OFS = 4'h8;
  localparam logic [31:0] DDRB_CTRL_RST = 32'h0000_0001;
  localparam logic [12:0] DDRB_MODE_RST = 13'h0032;
  // Mode field positions
  localparam int DDRB_BL_LSB = 0;
  localparam int DDRB_ORDER_BIT = 3;
  localparam int DDRB_LAT_LSB = 4;
  localparam int DDRB_DLL_BIT = 8;
  localparam int DDRB_AP_BIT = 10;
  // Mode codes
  localparam logic [2:0] DDRB_BL2 = 3'h1;
  localparam logic [2:0] DDRB_BL4 = 3'h2;
  localparam logic [2:0] DDRB_BL8 = 3'h3;
  localparam logic [2:0] DDRB_CL2 = 3'h2;
  localparam logic [2:0] DDRB_CL25 = 3'h6;
  localparam logic [2:0] DDRB_CL3 = 3'h3;
  // Latency in link clock half-periods
  localparam logic [3:0] DDRB_CL2_EDGES = 4'h4;
  localparam logic [3:0] DDRB_CL25_EDGES = 4'h5;
  localparam logic [3:0] DDRB_CL3_EDGES = 4'h6;
  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] DDRB_CMD_ACT = 3'h3;
  localparam logic [2:0] DDRB_CMD_RD = 3'h5;
  localparam logic [2:0] DDRB_CMD_WR = 3'h4;
  localparam logic [2:0] DDRB_CMD_PRE = 3'h2;
  localparam logic [2:0] DDRB_CMD_MRS = 3'h0;
  typedef struct packed {
    logic chip_sel_n;
    logic [2:0] op;
    logic bank_sel_hi;
    logic bank_sel_lo;
    logic [12:0] row_col_addr_bits;
  } ddrb_cmd_t;
  typedef enum logic [3:0] {
    DDRB_IDLE = 4'b0001,
    DDRB_RD_WAIT = 4'b0010,
    DDRB_RD_BURST = 4'b0100,
    DDRB_WR_BURST = 4'b1000
  } ddrb_state_t;
endpackage : ddrb_pkg

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top
  import ddrb_pkg::*;
;
  logic clk, rst, diff_clk_pos, diff_clk_neg, dq_oe_n, dqs_o, dqs_oe_n, dll_reset_pulse;
  logic ctl_dqs, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] dq_o, ctl_dq;
  logic [0:0] write_mask;
  ddrb_cmd_t cmd_in;
  logic [7:0] mem [int];
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int dll_cnt = 0;
  int oe_cnt = 0;
  logic [2:0] blc [3] = '{DDRB_BL8, DDRB_BL4, DDRB_BL2};
  logic [2:0] clc [3] = '{DDRB_CL2, DDRB_CL25, DDRB_CL3};
  int edg [3] = '{DDRB_CL2_EDGES, DDRB_CL25_EDGES, DDRB_CL3_EDGES};
  // Shared wires resolved from both enables
  wire [7:0] dq_w = dq_oe_n ? ctl_dq : dq_o;
  wire dqs_w = dqs_oe_n ? ctl_dqs : dqs_o;

  ddrb_core #(.DQ_W(8), .ROW_W(2), .COL_W(4)) i_dut (
    .clk(clk), .rst(rst), .diff_clk_pos(diff_clk_pos), .diff_clk_neg(diff_clk_neg),
    .cmd_in(cmd_in), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_i(dqs_w),
    .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n), .write_mask(write_mask),
    .dll_reset_pulse(dll_reset_pulse), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ddrb_ctl_model i_ctl (.diff_clk_pos(diff_clk_pos), .diff_clk_neg(diff_clk_neg),
    .cmd(cmd_in), .dq(ctl_dq), .dqs(ctl_dqs), .write_mask(write_mask));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Cycle ceiling and pin monitors
  always @(posedge clk) begin
    cycles++;
    if (dll_reset_pulse === 1'b1) dll_cnt++;
    if (dq_oe_n === 1'b0) oe_cnt++;
    if (cycles == 10000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // One write; each channel dropped once taken, bready held for the answer
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check(bresp, er);
        return;
      end
    end
    check(0, 1);
  endtask : axi_wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        check(rdata, e);
        check(rresp, er);
        return;
      end
    end
    check(0, 1);
  endtask : rd_chk
  // Column of beat k, wrapping inside the aligned block
  function automatic int col(int st, int bl, bit ilv, int k);
    int lo = ilv ? (st ^ k) : (st + k);
    return (st & ~(bl - 1)) | (lo & (bl - 1));
  endfunction : col
  // Write burst; masked bursts also ask for auto precharge
  task automatic wr(input int key, input int st, input int bl, input bit ilv, input bit msk);
    logic [7:0] d [8];
    logic [0:0] m [8];
    for (int k = 0; k < 8; k++) begin
      d[k] = 8'($urandom);
      m[k] = msk ? 1'($urandom) : 1'b0;
      if (k < bl && !m[k]) mem[key | col(st, bl, ilv, k)] = d[k];
    end
    i_ctl.send(DDRB_CMD_WR, 2'(key >> 6), (msk ? 13'h0400 : 13'h0000) | 13'(st));
    i_ctl.burst(d, m, bl);
    repeat (6) @(posedge clk);
  endtask : wr
  // Read with auto precharge; sample mid-beat
  task automatic rd(input int bl, input int st, input int key, input bit ilv, input int sel);
    int c0;
    int dt;
    int i;
    c0 = oe_cnt;
    i_ctl.send(DDRB_CMD_RD, 2'(key >> 6), 13'h0400 | 13'(st));
    for (i = 0; i < 80 && dq_oe_n !== 1'b0; i++) @(posedge clk);
    dt = int'($realtime - i_ctl.t_cmd) - edg[sel] * 400;
    check(dt >= 150 && dt <= 700, 1);
    repeat (2) @(posedge clk);
    for (int k = 0; k < bl; k++) begin
      check(dq_o, mem[key | col(st, bl, ilv, k)]);
      check(dqs_o, !k[0]);
      repeat (4) @(posedge clk);
    end
    @(posedge clk);
    check({dq_oe_n, dqs_o, dqs_oe_n}, 3'b101);
    check(oe_cnt - c0, bl * 4);
  endtask : rd

  initial begin
    logic [12:0] mode;
    int bl, bk, rw, st, key, d0;
    rst = 1'b1;
    wstrb = 4'hF;
    {awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
    void'($urandom(22199));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // Reset values, refusals, enable gate, bank bookkeeping
    rd_chk(DDRB_MODE_OFS, DDRB_MODE_RST, 2'h0);
    rd_chk(DDRB_CTRL_OFS, DDRB_CTRL_RST, 2'h0);
    rd_chk(4'hC, 32'h0, 2'h2);
    axi_wr(DDRB_MODE_OFS, 32'h0, 2'h2);
    axi_wr(DDRB_CTRL_OFS, 32'h0, 2'h0);
    i_ctl.send(DDRB_CMD_ACT, 2'h3, 13'h0000);
    rd_chk(DDRB_STAT_OFS, 32'h10, 2'h0);
    axi_wr(DDRB_CTRL_OFS, 32'h1, 2'h0);
    i_ctl.send(DDRB_CMD_ACT, 2'h3, 13'h0001);
    i_ctl.send(DDRB_CMD_ACT, 2'h1, 13'h0002);
    rd_chk(DDRB_STAT_OFS, 32'h1A, 2'h0);
    i_ctl.send(DDRB_CMD_PRE, 2'h0, 13'h0400);
    i_ctl.send(DDRB_CMD_MRS, 2'h1, 13'h0000);
    rd_chk(DDRB_MODE_OFS, DDRB_MODE_RST, 2'h0);
    // Every length, order and latency; banks idle at each load
    for (int i = 0; i < 6; i++) begin
      bl = 8 >> (i % 3);
      mode = {4'h0, i == 0, 1'b0, clc[i % 3], 1'(i / 3), blc[i % 3]};
      d0 = dll_cnt;
      i_ctl.send(DDRB_CMD_MRS, 2'h0, mode);
      repeat (4) @(posedge clk);
      check(dll_cnt - d0, i == 0);
      rd_chk(DDRB_MODE_OFS, mode & 13'h1EFF, 2'h0);
      if (i == 0) i_ctl.settle();
      if (i % 3 != 0) begin
        i_ctl.send(DDRB_CMD_ACT, 2'(bk), 13'(rw));
        rd(bl, st, key, i / 3, i % 3);
      end
      bk = $urandom_range(3);
      rw = $urandom_range(3);
      st = $urandom_range(15);
      key = (bk * 4 + rw) * 16;
      i_ctl.send(DDRB_CMD_ACT, 2'(bk), 13'(rw));
      wr(key, st, bl, i / 3, 1'b0);
      wr(key, st ^ 1, bl, i / 3, 1'b1);
      rd_chk(DDRB_STAT_OFS, 32'h10, 2'h0);
      i_ctl.send(DDRB_CMD_ACT, 2'(bk), 13'(rw));
      rd_chk(DDRB_STAT_OFS, 32'h10 | (1 << bk), 2'h0);
      rd(bl, st, key, i / 3, i % 3);
      rd_chk(DDRB_STAT_OFS, 32'h10, 2'h0);
    end
    // Read to a closed bank must stay silent
    d0 = oe_cnt;
    i_ctl.send(DDRB_CMD_RD, 2'h2, 13'h0000);
    repeat (40) @(posedge clk);
    check(oe_cnt - d0, 0);
    end_of_test();
  end
endmodule : tb_top
